//--- src/adc_port_top.sv
// Control mode selection, sync generation, modulator rate and serial readout port
`timescale 1ns/1ns
`default_nettype none
module adc_port_top (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        mode_strap_i,
    input  wire logic        hard_reset_n_i,
    input  wire logic [3:0]  general_purpose_config_pins_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        sdi_i,
    input  wire logic [23:0] result_i,
    input  wire logic [7:0]  status_i,
    input  wire logic        result_valid_i,
    output logic             reg_mode_o,
    output logic             dout_o,
    output logic             dout_oe_o,
    output logic             conversion_ready_output_o,
    output logic             sync_out_o,
    output logic             mod_tick_o,
    output logic [1:0]       power_mode_o,
    output logic             ain_prebuf_en_o,
    output logic             ref_prebuf_en_o
);
    localparam int FB = adc_port_pkg::FRAME_BITS;
    localparam int SCW = $clog2(adc_port_pkg::SYNC_PULSE_CYC + 1);
    localparam logic [SCW-1:0] SYNC_LEN = SCW'(adc_port_pkg::SYNC_PULSE_CYC);

    // Pin synchronisers
    logic [2:0]  spi_s;
    logic [3:0]  cfg_s;
    logic [1:0]  misc_s;
    pin_sync #(.WIDTH(3)) u_sync_spi (
        .clk_i (clk_i),
        .srst_i(srst_i),
        .d_i   ({sclk_i, cs_n_i, sdi_i}),
        .q_o   (spi_s)
    );
    pin_sync #(.WIDTH(4)) u_sync_cfg (
        .clk_i (clk_i),
        .srst_i(srst_i),
        .d_i   (general_purpose_config_pins_i),
        .q_o   (cfg_s)
    );
    pin_sync #(.WIDTH(2)) u_sync_misc (
        .clk_i (clk_i),
        .srst_i(srst_i),
        .d_i   ({mode_strap_i, hard_reset_n_i}),
        .q_o   (misc_s)
    );

    wire sclk_s    = spi_s[2];
    wire cs_act    = ~spi_s[1];
    wire sdi_s     = spi_s[0];
    wire strap_s   = misc_s[1];
    wire reset_any = srst_i | ~misc_s[0];

    // Control mode, caught once the synchronisers have flushed their reset value;
    // the hard reset line reading high marks that, since it shares the strap's synchroniser
    logic strap_done_r;
    logic reg_mode_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            strap_done_r <= 1'b0;
            reg_mode_r   <= 1'b0;
            reg_mode_o   <= 1'b0;
        end else begin
            reg_mode_o <= reg_mode_r; // Hard reset keeps the captured mode
            if (!strap_done_r && misc_s[0]) begin
                strap_done_r <= 1'b1;
                reg_mode_r   <= strap_s;
            end
        end
    end
    wire pin_mode = strap_done_r & ~reg_mode_r;

    // Edge detection on synchronised serial lines
    logic sclk_q_r;
    logic cs_q_r;
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            sclk_q_r <= 1'b1;
            cs_q_r   <= 1'b0;
        end else begin
            sclk_q_r <= sclk_s;
            cs_q_r   <= cs_act;
        end
    end
    // Clock edges only count while selected, in either clock polarity
    wire sclk_rise = cs_act & sclk_s & ~sclk_q_r;
    wire sclk_fall = cs_act & ~sclk_s & sclk_q_r;
    wire cs_start  = cs_act & ~cs_q_r;

    // Result holding register and ready flag
    logic [23:0] res_hold_r;
    logic [7:0]  stat_hold_r;
    logic        ready_r;
    logic        res_taken;
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            res_hold_r  <= '0;
            stat_hold_r <= '0;
            ready_r     <= 1'b0;
        end else if (result_valid_i) begin
            res_hold_r  <= result_i;
            stat_hold_r <= status_i;
            ready_r     <= 1'b1; // Set wins over a readback starting this cycle
        end else if (res_taken) begin
            ready_r     <= 1'b0;
        end
    end

    // Configuration registers, writable only in register mode
    logic [7:0] iface_r;
    logic [7:0] power_r;
    logic       wr_en;
    logic [6:0] addr_r;
    logic [7:0] wdata;
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            iface_r <= adc_port_pkg::IFACE_RESET;
            power_r <= adc_port_pkg::POWER_RESET;
        end else if (wr_en && reg_mode_r) begin
            if (addr_r == adc_port_pkg::REG_IFACE) iface_r <= wdata;
            if (addr_r == adc_port_pkg::REG_POWER) power_r <= wdata;
        end
    end
    wire cont_rd   = iface_r[adc_port_pkg::IF_CONT_BIT];
    wire app_stat  = iface_r[adc_port_pkg::IF_STAT_BIT];
    wire app_crc   = iface_r[adc_port_pkg::IF_CRC_BIT];
    wire rdy_merge = iface_r[adc_port_pkg::IF_RDYDOUT_BIT];
    wire stream    = pin_mode | (reg_mode_r & cont_rd);

    // CRC over the result word, MSB first
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = adc_port_pkg::CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ adc_port_pkg::CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // Frame builders
    wire [7:0]  crc_byte  = crc8(res_hold_r);
    wire [15:0] tail      = app_stat ? {stat_hold_r, app_crc ? crc_byte : 8'h00}
                                     : {app_crc ? crc_byte : 8'h00, 8'h00};
    localparam int LEN_W_T = adc_port_pkg::LEN_W;
    wire [LEN_W_T-1:0] tail_len;
    assign tail_len = LEN_W_T'({app_stat, 3'b000}) + LEN_W_T'({app_crc, 3'b000});
    wire [FB-1:0] pin_frame  = {res_hold_r, stat_hold_r, 8'h00};
    wire [FB-1:0] cont_frame = {res_hold_r, tail};
    wire [LEN_W_T-1:0] pin_len  = adc_port_pkg::LEN_RESULT + adc_port_pkg::LEN_BYTE;
    wire [LEN_W_T-1:0] cont_len = adc_port_pkg::LEN_RESULT + tail_len;

    // Serial command state machine
    adc_port_pkg::spi_state_t st_r;
    adc_port_pkg::spi_state_t st_nxt;
    logic [3:0] bit_r;
    logic [7:0] sr_r;
    logic       shifting_r;
    wire  [7:0] sr_in    = {sr_r[6:0], sdi_s};
    wire        byte_end = sclk_rise & (bit_r == 4'h7);
    wire        is_read  = sr_in[adc_port_pkg::CMD_READ_BIT];
    wire [6:0]  cmd_addr = sr_in[6:0];
    assign wdata = sr_in;
    assign wr_en = (st_r == adc_port_pkg::ST_WDATA) & byte_end & cs_act;

    // Addressed read frame
    logic [FB-1:0]      rd_frame;
    logic [LEN_W_T-1:0] rd_len;
    always_comb begin
        rd_frame = '0;
        rd_len   = adc_port_pkg::LEN_BYTE;
        case (cmd_addr)
            adc_port_pkg::REG_RESULT: begin
                rd_frame = {res_hold_r, 16'h0000};
                rd_len   = adc_port_pkg::LEN_RESULT;
            end
            adc_port_pkg::REG_IFACE: rd_frame = {iface_r, 32'h00000000};
            adc_port_pkg::REG_POWER: rd_frame = {power_r, 32'h00000000};
            default: rd_frame = '0;
        endcase
    end

    wire cmd_read  = (st_r == adc_port_pkg::ST_CMD) & byte_end & is_read;
    wire new_start = stream & (cs_start | (cs_act & result_valid_i & ~shifting_r));
    shift_if sif ();
    assign sif.load  = new_start | cmd_read;
    assign sif.frame = cmd_read ? rd_frame : (pin_mode ? pin_frame : cont_frame);
    assign sif.len   = cmd_read ? rd_len : (pin_mode ? pin_len : cont_len);
    assign sif.adv   = sclk_fall & (st_r == adc_port_pkg::ST_RDATA);
    assign sif.fill  = pin_mode & sdi_s;
    assign res_taken = new_start | (cmd_read & (cmd_addr == adc_port_pkg::REG_RESULT));

    tx_shifter u_shifter (
        .clk_i (clk_i),
        .srst_i(reset_any),
        .sif   (sif)
    );

    // Next state: strapped and continuous modes go straight to data out
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            adc_port_pkg::ST_IDLE:  if (cs_start) st_nxt = stream ? adc_port_pkg::ST_RDATA
                                                                  : adc_port_pkg::ST_CMD;
            adc_port_pkg::ST_CMD:   if (byte_end) st_nxt = is_read ? adc_port_pkg::ST_RDATA
                                                                   : adc_port_pkg::ST_WDATA;
            adc_port_pkg::ST_WDATA: if (byte_end) st_nxt = adc_port_pkg::ST_IDLE;
            adc_port_pkg::ST_RDATA: st_nxt = adc_port_pkg::ST_RDATA;
            default:                st_nxt = adc_port_pkg::ST_IDLE;
        endcase
        if (!cs_act || !strap_done_r) st_nxt = adc_port_pkg::ST_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            st_r <= adc_port_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bit counter, input shift register and command address on rising edges
    always_ff @(posedge clk_i) begin
        if (reset_any || !cs_act || cs_start) begin
            bit_r  <= '0;
            sr_r   <= '0;
            addr_r <= '0;
        end else if (sclk_rise) begin
            bit_r <= (bit_r == 4'h7) ? 4'h0 : bit_r + 4'h1;
            sr_r  <= sr_in;
            if (byte_end && st_r == adc_port_pkg::ST_CMD) addr_r <= cmd_addr;
        end
    end

    // Marks that the current frame has begun shifting, so a late result does not reload it
    always_ff @(posedge clk_i) begin
        if (reset_any || !cs_act || sif.load) begin
            shifting_r <= 1'b0;
        end else if (sif.adv) begin
            shifting_r <= 1'b1;
        end
    end

    // Data pin: shifter bit once clocking, ready merged low before the first edge
    wire dout_val = (reg_mode_r & rdy_merge & ~shifting_r) ? ~ready_r : sif.out;
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            dout_o    <= 1'b0;
            dout_oe_o <= 1'b0;
        end else begin
            dout_o    <= dout_val;
            dout_oe_o <= cs_act & strap_done_r;
        end
    end

    // Ready output; with merging selected it stays low and the data pin carries it
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            conversion_ready_output_o <= 1'b0;
        end else begin
            conversion_ready_output_o <= ready_r & ~(reg_mode_r & rdy_merge);
        end
    end

    // Sync output: reset release and config pin toggles, strapped mode only
    logic           rst_pend_r;
    logic [3:0]     cfg_q_r;
    logic [SCW-1:0] sync_cnt_r;
    wire  rst_fire = rst_pend_r & strap_done_r;
    wire  pin_tog  = strap_done_r & ~rst_pend_r & (cfg_s != cfg_q_r);
    wire  sync_go  = pin_mode & (rst_fire | pin_tog);
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            rst_pend_r <= 1'b1;
            cfg_q_r    <= '0;
            sync_cnt_r <= '0;
            sync_out_o <= 1'b0;
        end else begin
            if (strap_done_r) rst_pend_r <= 1'b0;
            cfg_q_r <= cfg_s;
            if (sync_go) begin
                sync_cnt_r <= SYNC_LEN;
                sync_out_o <= 1'b1;
            end else if (sync_cnt_r > SCW'(1)) begin
                sync_cnt_r <= sync_cnt_r - SCW'(1);
            end else begin
                sync_cnt_r <= '0;
                sync_out_o <= 1'b0;
            end
        end
    end

    // Power mode and modulator divide selection
    wire [1:0] pin_pm = cfg_s[3:2];
    logic [1:0] pm_sel;
    logic [4:0] div_sel;
    always_comb begin
        pm_sel  = adc_port_pkg::PM_FAST;
        div_sel = adc_port_pkg::DIV_2;
        if (reg_mode_r) begin
            pm_sel = power_r[adc_port_pkg::PWR_LSB +: 2];
            case (power_r[adc_port_pkg::DIV_LSB +: 2])
                2'b00:   div_sel = adc_port_pkg::DIV_2;
                2'b01:   div_sel = adc_port_pkg::DIV_4;
                2'b10:   div_sel = adc_port_pkg::DIV_8;
                default: div_sel = adc_port_pkg::DIV_16;
            endcase
        end else begin
            case (pin_pm)
                2'b01:   begin pm_sel = adc_port_pkg::PM_MEDIAN; div_sel = adc_port_pkg::DIV_4;  end
                2'b10:   begin pm_sel = adc_port_pkg::PM_LOW;    div_sel = adc_port_pkg::DIV_16; end
                default: begin pm_sel = adc_port_pkg::PM_FAST;   div_sel = adc_port_pkg::DIV_2;  end
            endcase
        end
    end

    // Modulator clock enable divider; a ratio change keeps the count, which wraps on the next edge if already past the new limit
    logic [4:0] div_cnt_r;
    wire        div_wrap = (div_cnt_r >= div_sel - 5'h01);
    always_ff @(posedge clk_i) begin
        if (reset_any || !strap_done_r) begin
            div_cnt_r  <= '0;
            mod_tick_o <= 1'b0;
        end else begin
            div_cnt_r  <= div_wrap ? 5'h00 : div_cnt_r + 5'h01;
            mod_tick_o <= div_wrap;
        end
    end

    // Mode dependent static controls
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            power_mode_o    <= adc_port_pkg::PM_FAST;
            ain_prebuf_en_o <= 1'b0;
            ref_prebuf_en_o <= 1'b0;
        end else begin
            power_mode_o    <= pm_sel;
            ain_prebuf_en_o <= pin_mode | (reg_mode_r & power_r[adc_port_pkg::AIN_BUF_BIT]);
            ref_prebuf_en_o <= pin_mode | (reg_mode_r & power_r[adc_port_pkg::REF_BUF_BIT]);
        end
    end
endmodule
`default_nettype wire

//--- shared/adc_port_pkg.sv
// Constants and types of the converter's readout and control port
package adc_port_pkg;
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          RESULT_BITS     = 24;
    localparam int          STATUS_BITS     = 8;
    localparam int          CRC_BITS        = 8;
    localparam int          FRAME_BITS      = 40;
    localparam int          LEN_W           = 6;
    localparam int          CMD_BITS        = 8;
    localparam int          CFG_PINS        = 4;
    // Instruction byte: bit 7 set means read, bits 6..0 address
    localparam int          CMD_READ_BIT    = 7;
    localparam logic [6:0]  REG_IFACE       = 7'h14;
    localparam logic [6:0]  REG_POWER       = 7'h15;
    localparam logic [6:0]  REG_RESULT      = 7'h2c;
    // Interface format register fields
    localparam int          IF_CONT_BIT     = 0;
    localparam int          IF_STAT_BIT     = 1;
    localparam int          IF_CRC_BIT      = 2;
    localparam int          IF_RDYDOUT_BIT  = 3;
    localparam logic [7:0]  IFACE_RESET     = 8'h00;
    // Power and clock register fields
    localparam int          PWR_LSB         = 0;
    localparam int          DIV_LSB         = 4;
    localparam int          AIN_BUF_BIT     = 6;
    localparam int          REF_BUF_BIT     = 7;
    localparam logic [7:0]  POWER_RESET     = 8'h00;
    // Frame lengths in bits
    localparam logic [LEN_W-1:0] LEN_BYTE   = 6'h08;
    localparam logic [LEN_W-1:0] LEN_RESULT = 6'h18;
    // Modulator divide ratios
    localparam logic [4:0]  DIV_2           = 5'h02;
    localparam logic [4:0]  DIV_4           = 5'h04;
    localparam logic [4:0]  DIV_8           = 5'h08;
    localparam logic [4:0]  DIV_16          = 5'h10;
    // CRC-8, polynomial x^8+x^2+x+1
    localparam logic [7:0]  CRC_POLY        = 8'h07;
    localparam logic [7:0]  CRC_INIT        = 8'h00;
    // Sync output pulse width
    localparam int          SYNC_PULSE_NS   = 100;
    localparam int          SYNC_PULSE_CYC  = (SYNC_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {
        PM_LOW    = 2'b00,
        PM_MEDIAN = 2'b01,
        PM_FAST   = 2'b10
    } power_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CMD   = 2'b01,
        ST_WDATA = 2'b10,
        ST_RDATA = 2'b11
    } spi_state_t;
endpackage

//--- shared/shift_if.sv
// Link between the port controller and the output shift register
`timescale 1ns/1ns
`default_nettype none
interface shift_if;
    logic                                  load;
    logic [adc_port_pkg::FRAME_BITS-1:0]   frame;
    logic [adc_port_pkg::LEN_W-1:0]        len;
    logic                                  adv;
    logic                                  fill;
    logic                                  out;
    logic                                  busy;

    modport ctrl (output load, frame, len, adv, fill, input out, busy);
    modport shifter (input load, frame, len, adv, fill, output out, busy);
endinterface
`default_nettype wire

//--- src/pin_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- src/tx_shifter.sv
// Output shift register: frame MSB first, then the fill bit once empty
`timescale 1ns/1ns
`default_nettype none
module tx_shifter (
    input  wire logic clk_i,
    input  wire logic srst_i,
    shift_if.shifter  sif
);
    logic [adc_port_pkg::FRAME_BITS-1:0] sh_r;
    logic [adc_port_pkg::LEN_W-1:0]      cnt_r;
    logic                                out_r;

    assign sif.out  = out_r;
    assign sif.busy = (cnt_r != '0);

    // Load wins over advance; each advance is one falling serial clock edge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sh_r  <= '0;
            cnt_r <= '0;
            out_r <= 1'b0;
        end else if (sif.load) begin
            sh_r  <= sif.frame;
            cnt_r <= sif.len;
        end else if (sif.adv) begin
            if (cnt_r != '0) begin
                out_r <= sh_r[adc_port_pkg::FRAME_BITS-1];
                sh_r  <= {sh_r[adc_port_pkg::FRAME_BITS-2:0], sif.fill};
                cnt_r <= cnt_r - 1'b1;
            end else begin
                out_r <= sif.fill;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/adc_port_asserts.sv
// Assertions on the converter readout port pins
`timescale 1ns/1ns
`default_nettype none
module adc_port_asserts (
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic [3:0] general_purpose_config_pins_i,
    input wire logic       cs_n_i,
    input wire logic       result_valid_i,
    input wire logic       reg_mode_o,
    input wire logic       dout_oe_o,
    input wire logic       conversion_ready_output_o,
    input wire logic       sync_out_o,
    input wire logic       mod_tick_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Sync pulse is five cycles high, then low
    sequence s_sync_pulse;
        sync_out_o [*5] ##1 !sync_out_o;
    endsequence
    // Reset values must show even while reset is held
    a_reset_vals: assert property (disable iff (1'b0) srst_i |=> !reg_mode_o && !sync_out_o && !dout_oe_o)
        else $error("outputs not at reset values");
    // The mode output may move only as the strap capture lands, four edges after reset ends (the check sees it on the fifth)
    a_mode_hold: assert property ($changed(reg_mode_o) |-> $past(srst_i, 5))
        else $error("control mode changed");
    a_sync_width: assert property ($rose(sync_out_o) |-> s_sync_pulse)
        else $error("sync pulse width wrong");
    a_sync_pins: assert property (!reg_mode_o && $changed(general_purpose_config_pins_i) |-> ##[1:8] $rose(sync_out_o))
        else $error("no sync after pin change");
    a_tick_pulse: assert property (mod_tick_o |=> !mod_tick_o)
        else $error("modulator tick too long");
    a_oe_idle: assert property (cs_n_i [*6] |-> !dout_oe_o)
        else $error("data out driven while deselected");
    a_ready_set: assert property (!reg_mode_o && result_valid_i |-> ##[1:3] conversion_ready_output_o)
        else $error("ready not raised");
    a_ready_clear: assert property (!reg_mode_o && $fell(cs_n_i) |-> ##[3:6] !conversion_ready_output_o)
        else $error("ready not cleared by frame start");
endmodule
`default_nettype wire

//--- verification/spi_host_model.sv
// Serial host model: mode 3 master clocking whole frames
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input  wire logic clk_i,
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o
);
    int half = 6;
    // Clock idles high and stands still between frames
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        sdi_o = 1'b1;
    end
    // Drive on falling, sample on rising; phases stay long enough for the synchronisers
    task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
        rx = 40'h0;
        cs_n_o = 1'b0;
        repeat (half) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            #2 sclk_o = 1'b0;
            sdi_o = tx[39-i];
            repeat (half) @(posedge clk_i);
            #2 rx = {rx[38:0], dout_i};
            sclk_o = 1'b1;
            repeat (half) @(posedge clk_i);
        end
        #2 cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // Released line must not keep its last value
        repeat (half) @(posedge clk_i);
        #2;
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the converter readout port
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        mode_strap_i = 1'b0;
    logic        hard_reset_n_i = 1'b1;
    logic [3:0]  general_purpose_config_pins_i = 4'h0;
    logic [23:0] result_i = 24'h0;
    logic [7:0]  status_i = 8'h0;
    logic        result_valid_i = 1'b0;
    wire logic   sclk_i, cs_n_i, sdi_i;
    logic        reg_mode_o, dout_o, dout_oe_o, conversion_ready_output_o, sync_out_o, mod_tick_o;
    logic        ain_prebuf_en_o, ref_prebuf_en_o;
    logic [1:0]  power_mode_o;
    logic [39:0] rx;
    int          fails = 0;
    int          compares = 0;
    // Data line is pulled up when released
    wire logic   dout_w = dout_oe_o ? dout_o : 1'b1;

    adc_port_top dut (.clk_i, .srst_i, .mode_strap_i, .hard_reset_n_i, .general_purpose_config_pins_i,
        .sclk_i, .cs_n_i, .sdi_i, .result_i, .status_i, .result_valid_i, .reg_mode_o, .dout_o, .dout_oe_o,
        .conversion_ready_output_o, .sync_out_o, .mod_tick_o, .power_mode_o, .ain_prebuf_en_o, .ref_prebuf_en_o);
    spi_host_model host (.clk_i, .dout_i(dout_w), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i));

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // Whole run needs a few thousand cycles
    initial begin
        #1_000_000;
        fails++;
        test_done;
    end

    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Ends two ns past an edge, where inputs change and outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic power_up(input logic strap);
        srst_i = 1'b1;
        mode_strap_i = strap;
        cyc(5);
        srst_i = 1'b0;
    endtask
    task automatic convert(input logic [23:0] r, input logic [7:0] s);
        result_i = r;
        status_i = s;
        result_valid_i = 1'b1;
        cyc(1);
        result_valid_i = 1'b0;
        cyc(3);
        check("ready", 40'(conversion_ready_output_o), 40'h1);
    endtask
    task automatic sync_wait(input string nm);
        logic got;
        got = 1'b0;
        repeat (14) begin
            cyc(1);
            got |= sync_out_o;
        end
        check(nm, 40'(got), 40'h1);
    endtask
    task automatic tick_gap(input int exp);
        int n;
        n = 0;
        while (mod_tick_o !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (mod_tick_o !== 1'b1 && n < 40);
        check("tick spacing", 40'(n), 40'(exp));
    endtask
    // Bitwise CRC-8, polynomial 0x07, seed zero, result MSB first
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    task automatic t_pins;
        logic [1:0] pm_t [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
        int gap_t [4] = '{2, 4, 16, 2};
        for (int i = 0; i < 4; i++) begin
            general_purpose_config_pins_i = {i[1:0], ~i[1:0]};
            sync_wait("sync on pin change");
            check("power mode", 40'(power_mode_o), 40'(pm_t[i]));
            tick_gap(gap_t[i]);
        end
        check("prebufs", 40'({ain_prebuf_en_o, ref_prebuf_en_o}), 40'h3);
    endtask
    // Write attempt, pass-through tail, then a slow host
    task automatic t_strap;
        convert(24'h812345, 8'ha5);
        host.xfer(40'h140f000180, 34, rx);
        check("strapped frame", rx, {6'h0, 24'h812345, 8'ha5, 2'h2});
        host.half = 10;
        convert(24'h00ff00, 8'h3c);
        host.xfer(40'h0, 32, rx);
        host.half = 6;
        check("slow frame", rx, {8'h0, 24'h00ff00, 8'h3c});
        check("ready cleared", 40'(conversion_ready_output_o), 40'h0);
    endtask
    task automatic t_hard;
        hard_reset_n_i = 1'b0;
        cyc(4);
        hard_reset_n_i = 1'b1;
        sync_wait("sync after hard reset");
        check("mode kept", 40'(reg_mode_o), 40'h0);
    endtask
    task automatic t_regs;
        cyc(6);
        check("register mode", 40'(reg_mode_o), 40'h1);
        mode_strap_i = 1'b0;
        host.xfer({16'h15d5, 24'h0}, 16, rx);
        check("mode held", 40'(reg_mode_o), 40'h1);
        check("power fields", 40'({power_mode_o, ain_prebuf_en_o, ref_prebuf_en_o}), 40'h7);
        tick_gap(4);
        host.xfer({16'h1532, 24'h0}, 16, rx);
        check("power fields", 40'({power_mode_o, ain_prebuf_en_o, ref_prebuf_en_o}), 40'h8);
        tick_gap(16);
        host.xfer({8'h95, 32'h0}, 16, rx);
        check("power readback", 40'(rx[7:0]), 40'h32);
        host.xfer({8'hff, 32'h0}, 16, rx);
        check("unmapped read", 40'(rx[7:0]), 40'h0);
        convert(24'h5a0f3c, 8'h11);
        host.xfer({8'hac, 32'h0}, 32, rx);
        check("result read", 40'(rx[23:0]), 40'h5a0f3c);
        // Ready merged into the data pin: low during the command byte while a result waits
        host.xfer({16'h1408, 24'h0}, 16, rx);
        host.xfer({8'h95, 32'h0}, 16, rx);
        check("merged idle", 40'(rx[15:0]), 40'hff32);
        result_valid_i = 1'b1;
        cyc(1);
        result_valid_i = 1'b0;
        cyc(3);
        check("ready held low", 40'(conversion_ready_output_o), 40'h0);
        host.xfer({8'h95, 32'h0}, 16, rx);
        check("merged ready", 40'(rx[15:0]), 40'h0032);
    endtask
    task automatic t_cont;
        host.xfer({16'h1407, 24'h0}, 16, rx);
        convert(24'hc3a501, 8'h66);
        host.xfer(40'h0, 40, rx);
        check("continuous frame", rx, {24'hc3a501, 8'h66, crc8(24'hc3a501)});
    endtask

    initial begin
        power_up(1'b0);
        sync_wait("sync after power-up");
        t_pins;
        t_strap;
        t_hard;
        power_up(1'b1);
        t_regs;
        t_cont;
        test_done;
    end
endmodule
bind adc_port_top adc_port_asserts chk (.clk_i, .srst_i, .general_purpose_config_pins_i, .cs_n_i, .result_valid_i,
    .reg_mode_o, .dout_oe_o, .conversion_ready_output_o, .sync_out_o, .mod_tick_o);
`default_nettype wire
